// ===== design/perf_page_pkg.sv
package perf_page_pkg;

  // Page that holds the performance counters, as written to the page port.
  localparam logic [7:0] STATUS_PAGE      = 8'h04;

  // Five-bit offsets of the sixteen locations inside the page.
  localparam logic [4:0] OFS_PRBS_ERR     = 5'h10;
  localparam logic [4:0] OFS_PRBS_SMF     = 5'h11;
  localparam logic [4:0] OFS_IRQ_VECTOR   = 5'h12;
  localparam logic [4:0] OFS_EBIT_HIGH    = 5'h13;
  localparam logic [4:0] OFS_EBIT_LOW     = 5'h14;
  localparam logic [4:0] OFS_JITTER       = 5'h15;
  localparam logic [4:0] OFS_OVF_LATCH    = 5'h16;
  localparam logic [4:0] OFS_SYNC_LOSS    = 5'h17;
  localparam logic [4:0] OFS_FAS_BIT      = 5'h18;
  localparam logic [4:0] OFS_RAI_CRC      = 5'h19;
  localparam logic [4:0] OFS_ERRORED_FAS  = 5'h1a;
  localparam logic [4:0] OFS_ALARM_LATCH  = 5'h1b;
  localparam logic [4:0] OFS_BPV_HIGH     = 5'h1c;
  localparam logic [4:0] OFS_BPV_LOW      = 5'h1d;
  localparam logic [4:0] OFS_CRC4_HIGH    = 5'h1e;
  localparam logic [4:0] OFS_CRC4_LOW     = 5'h1f;

  // Bit positions inside the overflow latch.
  localparam int OVF_PRBS_BIT    = 7;
  localparam int OVF_EBIT_BIT    = 6;
  localparam int OVF_JITTER_BIT  = 5;
  localparam int OVF_SYNC_BIT    = 4;
  localparam int OVF_FASBIT_BIT  = 3;
  localparam int OVF_EFAS_BIT    = 2;
  localparam int OVF_BPV_BIT     = 1;
  localparam int OVF_CRC4_BIT    = 0;

  // Counter widths and the width of the FAS error count.
  localparam int CNT8_W          = 8;
  localparam int CNT10_W         = 10;
  localparam int CNT16_W         = 16;
  localparam int FAS_ERR_W       = 3;

  // Words of margin before the jitter FIFO under- or overflows.
  localparam int JFIFO_MARGIN    = 4;

  // Reset values of the read port and of the overflow latch.
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] OVF_RESET   = 8'h00;

  // One access from the host on the parallel register port.
  typedef struct packed {
    logic       cs;     // Chip select, one cycle per access.
    logic       rd;     // Read strobe.
    logic       wr;     // Write strobe.
    logic [7:0] page;   // Currently selected register page.
    logic [4:0] addr;   // Offset within the page.
    logic [7:0] wdata;  // Write data.
  } host_req_s;

  // Single-cycle event strobes from the receive framer, plus the sync-lost level.
  typedef struct packed {
    logic                 prbs_err;   // One PRBS bit error.
    logic                 smf_rx;     // One CRC submultiframe received.
    logic                 ebit_err;   // One E-bit error.
    logic                 bpv;        // One bipolar violation.
    logic                 crc4_err;   // One CRC-4 error.
    logic                 fas_rx;     // A frame alignment signal arrived.
    logic [FAS_ERR_W-1:0] fas_errs;   // Bit errors in that alignment signal.
    logic                 frame_tick; // Start of each 125 us frame.
    logic                 sync_lost;  // Level: basic frame alignment lost.
  } line_events_s;

endpackage

// ===== design/wrap_counter.sv
`timescale 1ns/10ps

// Saturation-free event counter that wraps and reports each wrap.
module wrap_counter
  import perf_page_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int INC_W = 1
) (
  // Clock and reset.
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  // Control.
  input  wire logic [INC_W-1:0] inc_i,
  input  wire logic             clr_i,
  // Status.
  output logic      [WIDTH-1:0] cnt_o,
  output logic                  wrap_o
);

  // Refuse shapes that the adder cannot serve.
  if (INC_W < 1 || INC_W >= WIDTH) begin : g_bad_width
    $error("wrap_counter: INC_W must lie between 1 and WIDTH-1");
  end

  logic [WIDTH:0]   sum;    // Count plus increment with carry.
  logic [WIDTH-1:0] cnt_q;  // Held count.

  // Carry out of the adder marks the step from all ones past zero.
  always_comb begin
    sum    = {1'b0, cnt_q} + {{(WIDTH + 1 - INC_W){1'b0}}, inc_i};
    wrap_o = sum[WIDTH] & ~clr_i;
  end

  // A clear takes precedence over counting in the same cycle.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || clr_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= sum[WIDTH-1:0];
    end
  end

  assign cnt_o = cnt_q;

  // A wrap always leaves the count below the increment that caused it.
  a_wrap_below_inc: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    wrap_o |=> ({{(WIDTH - INC_W){1'b0}}, $past(inc_i)} > cnt_q))
    else $error("counter wrapped to a value not below its increment");

endmodule

// ===== design/perf_counter_page.sv
`timescale 1ns/10ps

module perf_counter_page
  import perf_page_pkg::*;
#(
  parameter int JFIFO_DEPTH = 32,
  parameter int FILL_W      = $clog2(JFIFO_DEPTH + 1)
) (
  // Clock and reset.
  input  wire logic              sys_clk_i,
  input  wire logic              srst_i,
  // Host register port.
  input  wire host_req_s         host_req_i,
  output logic       [7:0]       reg_rdata_o,
  output logic                   reg_rvalid_o,
  // Receive framer events.
  input  wire line_events_s      events_i,
  input  wire logic              irq_raise_i,
  input  wire logic  [7:0]       irq_vector_i,
  // Status bytes kept by neighbouring logic.
  input  wire logic  [1:0]       rai_crc_flags_i,
  input  wire logic  [7:0]       alarm_latch_i,
  // Jitter attenuator FIFO.
  input  wire logic  [FILL_W-1:0] jitter_fifo_fill_i,
  output logic                   jitter_rd_slow_o,
  output logic                   jitter_rd_fast_o
);

  //////////////////////////////////////////////////////////////////////////
  // Parameter checks and constants.
  //////////////////////////////////////////////////////////////////////////

  // The two guard bands must not overlap, or both would act at once.
  if (JFIFO_DEPTH <= 2 * JFIFO_MARGIN) begin : g_bad_depth
    $error("perf_counter_page: JFIFO_DEPTH too small for its margins");
  end
  if (FILL_W < $clog2(JFIFO_DEPTH + 1)) begin : g_bad_fill
    $error("perf_counter_page: FILL_W cannot hold a full FIFO count");
  end

  // Fill levels at or beyond which the read clock must be steered.
  localparam logic [FILL_W-1:0] LOW_MARK  = FILL_W'(JFIFO_MARGIN);
  localparam logic [FILL_W-1:0] HIGH_MARK =
    FILL_W'(JFIFO_DEPTH - JFIFO_MARGIN);

  //////////////////////////////////////////////////////////////////////////
  // Host access decode.
  //////////////////////////////////////////////////////////////////////////

  // True when an access targets this page and its upper half.
  function automatic logic hits_page(input host_req_s req);
    hits_page = req.cs && (req.page == STATUS_PAGE) && req.addr[4];
  endfunction

  logic rd_hit;       // Read strobe aimed at this page.
  logic wr_prbs;      // Write aimed at the PRBS error counter.
  logic rd_ovf;       // Read of the overflow latch.

  // Decode the three accesses that have effects.
  always_comb begin
    rd_hit  = hits_page(host_req_i) && host_req_i.rd;
    wr_prbs = hits_page(host_req_i) && host_req_i.wr &&
              (host_req_i.addr == OFS_PRBS_ERR);
    rd_ovf  = rd_hit && (host_req_i.addr == OFS_OVF_LATCH);
  end

  //////////////////////////////////////////////////////////////////////////
  // Jitter FIFO guard band.
  //////////////////////////////////////////////////////////////////////////

  logic near_low;     // Read pointer close to underflow.
  logic near_high;    // Read pointer close to overflow.
  logic near_q;       // Either condition, one cycle ago.
  logic jitter_step;  // Entry into the guard band.

  // Compare the fill level with both guard marks.
  always_comb begin
    near_low    = jitter_fifo_fill_i <= LOW_MARK;
    near_high   = jitter_fifo_fill_i >= HIGH_MARK;
    jitter_step = (near_low || near_high) && !near_q;
  end

  // Remember the previous band state to count entries only.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      near_q <= 1'b0;
    end else begin
      near_q <= near_low || near_high;
    end
  end

  // Slow the read clock near empty, speed it near full.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      jitter_rd_slow_o <= 1'b0;
      jitter_rd_fast_o <= 1'b0;
    end else begin
      jitter_rd_slow_o <= near_low;
      jitter_rd_fast_o <= near_high;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame synchronisation tracking.
  //////////////////////////////////////////////////////////////////////////

  logic lost_q;       // Previous sync-lost level.
  logic sync_drop;    // Transition from in sync to lost.
  logic lost_frame;   // One frame period spent out of sync.

  // Mark the moment sync is lost and each frame spent lost.
  always_comb begin
    sync_drop  = events_i.sync_lost && !lost_q;
    lost_frame = events_i.sync_lost && events_i.frame_tick;
  end

  // Hold the sync level for edge detection.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      lost_q <= 1'b0;
    end else begin
      lost_q <= events_i.sync_lost;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counters.
  //////////////////////////////////////////////////////////////////////////

  logic [CNT8_W-1:0]    prbs_err_cnt;     // PRBS errors.
  logic [CNT8_W-1:0]    prbs_smf_cnt;     // Submultiframes since write.
  logic [CNT10_W-1:0]   ebit_cnt;         // E-bit errors.
  logic [CNT8_W-1:0]    jitter_fifo_cnt;  // Guard band entries.
  logic [CNT8_W-1:0]    sync_loss_cnt;    // Frames without sync.
  logic [CNT8_W-1:0]    fas_bit_cnt;      // Alignment signal bit errors.
  logic [CNT8_W-1:0]    errored_fas_cnt;  // Bad alignment signals.
  logic [CNT16_W-1:0]   violation_cnt;    // Bipolar violations.
  logic [CNT10_W-1:0]   crc4_cnt;         // CRC-4 errors.
  logic [7:0]           ovf_set;          // Wrap strobes, latch layout.
  logic [FAS_ERR_W-1:0] fas_inc;          // Errors in a valid FAS.
  logic                 efas_inc;         // A FAS with any error.

  // Only a delivered alignment signal contributes errors.
  always_comb begin
    fas_inc  = events_i.fas_rx ? events_i.fas_errs : '0;
    efas_inc = events_i.fas_rx && (events_i.fas_errs != '0);
  end

  // PRBS errors on any routed channel.
  wrap_counter #(.WIDTH(CNT8_W), .INC_W(1)) u_prbs (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (events_i.prbs_err),
    .clr_i     (1'b0),
    .cnt_o     (prbs_err_cnt),
    .wrap_o    (ovf_set[OVF_PRBS_BIT])
  );

  // Submultiframes, restarted by any write to the PRBS counter.
  wrap_counter #(.WIDTH(CNT8_W), .INC_W(1)) u_smf (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (events_i.smf_rx),
    .clr_i     (wr_prbs),
    .cnt_o     (prbs_smf_cnt),
    .wrap_o    ()
  );

  // E-bit errors, ten bits wide.
  wrap_counter #(.WIDTH(CNT10_W), .INC_W(1)) u_ebit (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (events_i.ebit_err),
    .clr_i     (1'b0),
    .cnt_o     (ebit_cnt),
    .wrap_o    (ovf_set[OVF_EBIT_BIT])
  );

  // Entries into the jitter FIFO guard band.
  wrap_counter #(.WIDTH(CNT8_W), .INC_W(1)) u_jitter (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (jitter_step),
    .clr_i     (1'b0),
    .cnt_o     (jitter_fifo_cnt),
    .wrap_o    (ovf_set[OVF_JITTER_BIT])
  );

  // Frames spent out of sync, restarted when sync is lost.
  wrap_counter #(.WIDTH(CNT8_W), .INC_W(1)) u_sync (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (lost_frame),
    .clr_i     (sync_drop),
    .cnt_o     (sync_loss_cnt),
    .wrap_o    (ovf_set[OVF_SYNC_BIT])
  );

  // Total bit errors seen in alignment signals.
  wrap_counter #(.WIDTH(CNT8_W), .INC_W(FAS_ERR_W)) u_fasbit (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (fas_inc),
    .clr_i     (1'b0),
    .cnt_o     (fas_bit_cnt),
    .wrap_o    (ovf_set[OVF_FASBIT_BIT])
  );

  // Alignment signals holding at least one error.
  wrap_counter #(.WIDTH(CNT8_W), .INC_W(1)) u_efas (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (efas_inc),
    .clr_i     (1'b0),
    .cnt_o     (errored_fas_cnt),
    .wrap_o    (ovf_set[OVF_EFAS_BIT])
  );

  // Bipolar violations, sixteen bits wide.
  wrap_counter #(.WIDTH(CNT16_W), .INC_W(1)) u_bpv (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (events_i.bpv),
    .clr_i     (1'b0),
    .cnt_o     (violation_cnt),
    .wrap_o    (ovf_set[OVF_BPV_BIT])
  );

  // CRC-4 errors, ten bits wide.
  wrap_counter #(.WIDTH(CNT10_W), .INC_W(1)) u_crc4 (
    .sys_clk_i (sys_clk_i),
    .srst_i    (srst_i),
    .inc_i     (events_i.crc4_err),
    .clr_i     (1'b0),
    .cnt_o     (crc4_cnt),
    .wrap_o    (ovf_set[OVF_CRC4_BIT])
  );

  //////////////////////////////////////////////////////////////////////////
  // Overflow latch and interrupt vector.
  //////////////////////////////////////////////////////////////////////////

  logic [7:0] ovf_q;        // Sticky overflow flags.
  logic [7:0] irq_vector_q; // Category of the latest interrupt.

  // Reading clears, but a wrap in the same cycle still lands.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ovf_q <= OVF_RESET;
    end else begin
      ovf_q <= (rd_ovf ? 8'h00 : ovf_q) | ovf_set;
    end
  end

  // Capture the category whenever an interrupt is raised.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      irq_vector_q <= 8'h00;
    end else if (irq_raise_i) begin
      irq_vector_q <= irq_vector_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data.
  //////////////////////////////////////////////////////////////////////////

  logic [7:0] rd_mux;  // Byte selected by the current offset.

  // Select the byte; reads change nothing but the overflow latch.
  always_comb begin
    unique case (host_req_i.addr)
      OFS_PRBS_ERR:    rd_mux = prbs_err_cnt;
      OFS_PRBS_SMF:    rd_mux = prbs_smf_cnt;
      OFS_IRQ_VECTOR:  rd_mux = irq_vector_q;
      OFS_EBIT_HIGH:   rd_mux = {6'h00, ebit_cnt[9:8]};
      OFS_EBIT_LOW:    rd_mux = ebit_cnt[7:0];
      OFS_JITTER:      rd_mux = jitter_fifo_cnt;
      OFS_OVF_LATCH:   rd_mux = ovf_q;
      OFS_SYNC_LOSS:   rd_mux = sync_loss_cnt;
      OFS_FAS_BIT:     rd_mux = fas_bit_cnt;
      OFS_RAI_CRC:     rd_mux = {6'h00, rai_crc_flags_i};
      OFS_ERRORED_FAS: rd_mux = errored_fas_cnt;
      OFS_ALARM_LATCH: rd_mux = alarm_latch_i;
      OFS_BPV_HIGH:    rd_mux = violation_cnt[15:8];
      OFS_BPV_LOW:     rd_mux = violation_cnt[7:0];
      OFS_CRC4_HIGH:   rd_mux = {6'h00, crc4_cnt[9:8]};
      OFS_CRC4_LOW:    rd_mux = crc4_cnt[7:0];
      default:         rd_mux = 8'h00;
    endcase
  end

  // Register the answer one cycle after the read strobe.
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      reg_rdata_o  <= RDATA_RESET;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rdata_o  <= rd_hit ? rd_mux : 8'h00;
      reg_rvalid_o <= host_req_i.cs && host_req_i.rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.
  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  // Host reads the overflow latch.
  sequence s_ovf_read;
    rd_ovf;
  endsequence

  // Sync goes from held to lost.
  sequence s_sync_drop;
    !events_i.sync_lost ##1 events_i.sync_lost;
  endsequence

  a_prbs_count_step: assert property (
    events_i.prbs_err |=> prbs_err_cnt == $past(prbs_err_cnt) + 8'h01)
    else $error("PRBS error counter did not step by one");

  a_smf_write_clear: assert property (
    wr_prbs |=> prbs_smf_cnt == 8'h00)
    else $error("submultiframe counter not cleared by PRBS write");

  a_vector_capture: assert property (
    irq_raise_i ##1 (!irq_raise_i)[*2]
      |-> irq_vector_q == $past(irq_vector_i, 2))
    else $error("interrupt vector lost its captured category");

  a_ebit_wrap_flag: assert property (
    (events_i.ebit_err && ebit_cnt == 10'h3ff)
      |=> ebit_cnt == 10'h000 && ovf_q[OVF_EBIT_BIT])
    else $error("E-bit counter wrap did not raise its latch bit");

  a_jitter_steer: assert property (
    near_low |=> jitter_rd_slow_o && !jitter_rd_fast_o)
    else $error("read clock not slowed near FIFO underflow");

  a_latch_read_clear: assert property (
    s_ovf_read |=> reg_rdata_o == $past(ovf_q) && ovf_q == $past(ovf_set))
    else $error("overflow latch read did not return and clear");

  a_latch_holds: assert property (
    (!rd_ovf && ovf_q[OVF_CRC4_BIT]) |=> ovf_q[OVF_CRC4_BIT])
    else $error("CRC-4 overflow bit dropped without a read");

  a_sync_loss_zero: assert property (
    s_sync_drop |=> sync_loss_cnt == 8'h00)
    else $error("sync loss counter not zeroed on loss of sync");

  a_bpv_high_read: assert property (
    (rd_hit && host_req_i.addr == OFS_BPV_HIGH && !events_i.bpv)
      |=> reg_rdata_o == violation_cnt[15:8])
    else $error("violation upper byte read wrong");

  a_page_miss_zero: assert property (
    (host_req_i.cs && host_req_i.rd && host_req_i.page != STATUS_PAGE)
      |=> reg_rvalid_o && reg_rdata_o == 8'h00)
    else $error("read outside the status page returned data");

  a_read_no_disturb: assert property (
    (rd_hit && !events_i.crc4_err) |=> crc4_cnt == $past(crc4_cnt))
    else $error("counter changed by a plain read");

endmodule

// ===== dv/host_model.sv
`timescale 1ns/10ps

// Host on the register port; it changes the port on falling edges only.
module host_model
  import perf_page_pkg::*;
(
  // Clock.
  input  wire logic       sys_clk_i,
  // Register port.
  output host_req_s       host_req_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  // The port starts idle with no access.
  initial host_req_o = '0;

  // One access of one cycle; a read answer is taken in the next cycle.
  task automatic access(input logic [7:0] pg, input logic [4:0] ofs,
                        input logic w, input logic [7:0] wd,
                        output logic [7:0] rd_data);
    @(negedge sys_clk_i);
    host_req_o = '{1'b1, !w, w, pg, ofs, wd};
    @(negedge sys_clk_i);
    // Released lines show the inverse, never a stale value.
    host_req_o = '{1'b0, 1'b0, 1'b0, ~pg, ~ofs, ~wd};
    // The answer stands only in the cycle right after the strobe.
    rd_data = 8'hxx;
    if (!w && reg_rvalid_i === 1'b1) begin
      rd_data = reg_rdata_i;
    end
  endtask
endmodule

// ===== dv/tb.sv
`timescale 1ns/10ps

// Self-checking bench for the performance counter page.
module tb
  import perf_page_pkg::*;
;
  // One table row: event kind, pulse count, offset, expected byte.
  typedef struct packed {
    int         k;
    int         n;
    logic [4:0] ofs;
    logic [7:0] exp;
  } row_s;

  logic         sys_clk;   // Core clock.
  logic         srst;      // Synchronous reset.
  host_req_s    req;       // Host access.
  logic [7:0]   rdata;     // Read data.
  logic         rvalid;    // Read answer strobe.
  line_events_s ev;        // Framer strobes.
  logic         irq_raise; // Interrupt strobe.
  logic [7:0]   irq_vec;   // Interrupt category.
  logic [1:0]   rai;       // Neighbour status bits.
  logic [7:0]   alarm;     // Neighbour alarm byte.
  logic [5:0]   fill;      // Jitter FIFO fill.
  logic         slow;      // Read clock slow request.
  logic         fast;      // Read clock fast request.
  int           mismatches = 0;
  int           cmp_count = 0;
  int           cyc = 0;
  int           fills [6] = '{16, 4, 3, 16, 28, 16};
  row_s         rows [8] = '{'{0, 3, 5'h10, 8'h03}, '{1, 5, 5'h11, 8'h05},
    '{2, 2, 5'h14, 8'h02}, '{3, 4, 5'h1d, 8'h04}, '{3, 0, 5'h1c, 8'h00},
    '{4, 6, 5'h1f, 8'h06}, '{5, 2, 5'h18, 8'h06}, '{5, 0, 5'h1a, 8'h02}};

  perf_counter_page #(.JFIFO_DEPTH(32)) dut (
    .sys_clk_i(sys_clk), .srst_i(srst), .host_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .events_i(ev),
    .irq_raise_i(irq_raise), .irq_vector_i(irq_vec),
    .rai_crc_flags_i(rai), .alarm_latch_i(alarm),
    .jitter_fifo_fill_i(fill), .jitter_rd_slow_o(slow),
    .jitter_rd_fast_o(fast));

  host_model host (.sys_clk_i(sys_clk), .host_req_o(req),
    .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

  // Free-running 8 ns clock.
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      $display("ERROR %0t: run did not finish in time", $time);
      mismatches++;
      end_sim();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares one byte and reports a difference at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // Reads one location and compares it.
  task automatic rd(input logic [7:0] pg, input logic [4:0] ofs,
                    input logic [7:0] exp);
    logic [7:0] d;
    host.access(pg, ofs, 1'b0, 8'h00, d);
    chk(d, exp);
  endtask

  // Sets or clears one framer strobe; alignment signals carry 3 errors.
  task automatic set_ev(input int k, input logic v);
    case (k)
      0: ev.prbs_err = v;
      1: ev.smf_rx = v;
      2: ev.ebit_err = v;
      3: ev.bpv = v;
      4: ev.crc4_err = v;
      default: begin
        ev.fas_rx = v;
        ev.fas_errs = v ? 3'h3 : 3'h0;
      end
    endcase
  endtask

  // Holds one strobe high for n back-to-back cycles.
  task automatic pulse(input int k, input int n);
    if (n > 0) begin
      @(negedge sys_clk);
      set_ev(k, 1'b1);
      repeat (n) @(negedge sys_clk);
      set_ev(k, 1'b0);
    end
  endtask

  // Holds reset for 16 cycles.
  task automatic do_reset();
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
  endtask

  // Main sequence: reset values first, then the table, then the awkward cases.
  initial begin
    logic [7:0] d;
    srst = 1'b1;
    ev = '0;
    irq_raise = 1'b0;
    irq_vec = 8'h00;
    rai = 2'h0;
    alarm = 8'h00;
    fill = 6'h10;
    do_reset();
    for (int a = 16; a < 32; a++) begin
      rd(STATUS_PAGE, 5'(a), 8'h00);
    end
    $display("reset test done");
    foreach (rows[i]) begin
      pulse(rows[i].k, rows[i].n);
      rd(STATUS_PAGE, rows[i].ofs, rows[i].exp);
    end
    $display("table test done");
    do_reset();
    @(negedge sys_clk);
    for (int k = 0; k < 6; k++) set_ev(k, 1'b1);
    repeat (1024) @(negedge sys_clk);
    for (int k = 0; k < 6; k++) set_ev(k, 1'b0);
    rd(STATUS_PAGE, 5'h10, 8'h00);
    rd(STATUS_PAGE, 5'h1c, 8'h04);
    rd(STATUS_PAGE, 5'h1c, 8'h04);
    rd(STATUS_PAGE, 5'h13, 8'h00);
    rd(STATUS_PAGE, 5'h1e, 8'h00);
    rd(STATUS_PAGE, 5'h16, 8'hcd);
    rd(STATUS_PAGE, 5'h16, 8'h00);
    pulse(3, 64512);
    rd(STATUS_PAGE, 5'h1d, 8'h00);
    rd(STATUS_PAGE, 5'h16, 8'h02);
    $display("overflow test done");
    pulse(1, 5);
    pulse(0, 2);
    host.access(STATUS_PAGE, 5'h10, 1'b1, 8'h5a, d);
    rd(STATUS_PAGE, 5'h11, 8'h00);
    rd(STATUS_PAGE, 5'h10, 8'h02);
    $display("write clear test done");
    @(negedge sys_clk);
    ev.sync_lost = 1'b1;
    ev.frame_tick = 1'b1;
    repeat (4) @(negedge sys_clk);
    ev.frame_tick = 1'b0;
    ev.sync_lost = 1'b0;
    rd(STATUS_PAGE, 5'h17, 8'h03);
    ev.sync_lost = 1'b1;
    rd(STATUS_PAGE, 5'h17, 8'h00);
    ev.frame_tick = 1'b1;
    repeat (256) @(negedge sys_clk);
    ev.frame_tick = 1'b0;
    rd(STATUS_PAGE, 5'h17, 8'h00);
    $display("sync loss test done");
    foreach (fills[i]) begin
      @(negedge sys_clk);
      fill = 6'(fills[i]);
      repeat (2) @(negedge sys_clk);
      chk({6'h0, slow, fast}, {6'h0, fills[i] <= 4, fills[i] >= 28});
    end
    rd(STATUS_PAGE, 5'h15, 8'h02);
    repeat (254) begin
      fill = 6'h04;
      @(negedge sys_clk);
      fill = 6'h10;
      @(negedge sys_clk);
    end
    rd(STATUS_PAGE, 5'h15, 8'h00);
    rd(STATUS_PAGE, 5'h16, 8'h30);
    $display("jitter test done");
    @(negedge sys_clk);
    irq_raise = 1'b1;
    irq_vec = 8'h5a;
    alarm = 8'h6e;
    rai = 2'h2;
    @(negedge sys_clk);
    irq_raise = 1'b0;
    rd(STATUS_PAGE, 5'h12, 8'h5a);
    rd(STATUS_PAGE, 5'h1b, 8'h6e);
    rd(STATUS_PAGE, 5'h19, 8'h02);
    rd(8'h03, 5'h12, 8'h00);
    rd(STATUS_PAGE, 5'h0f, 8'h00);
    $display("vector and decode test done");
    end_sim();
  end
endmodule
